// >>> inc/piu_pkg.sv
// Constants, register map and sequencer states of the priority interrupt unit
// Behaviour
// - Return pops flags, code segment if saved, PC high, PC low, then sets enable.
// - Concurrent return without segment saving resumes fetching through code segment.
// - Requests pending while enable is clear wait until enable is set again.
// - Concurrent mode keeps no priority record; enabled requests still need a level below current level.
// - Nested acknowledge sets the priority stack bit numbered by current level.
// - Nested acknowledge then loads current level with the request's priority.
// - Entry: clear enable, save and load level if nested, push PCL, PCH, segment if saved, flags, then load vector.
// - Entry copies interrupt segment into code segment, else fetches via interrupt segment.
// - Nested return restores current level from the priority stack.
// - Nested return without saving uses code segment only when back in main code.
// - Eight sources in four pairs; only A0 and D0 have external lines.
// - Edge select 1 means rising, 0 falling; bits 0 to 7.
// - Each source maskable; A0 mask at bit 7 down to D1 at bit 0.
// - Two-bit pair field; even channel even level, odd channel next odd level.
// - A0 source is line zero when select is 1 (reset), else timer/watchdog.
// - D0 source is line six when select is 0, else clock control unit.
// - Acknowledge only when request level is strictly below current level.
// - Current level is three bits and resets to 7.
// - Arbitration select: clear is concurrent (reset), set is nested.
package piu_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam int unsigned APB_AW     = 10;
  localparam logic [7:0]  IDX_CTRL   = 8'he6;
  localparam logic [7:0]  IDX_CFG    = 8'hf0;
  localparam logic [7:0]  IDX_EDGE   = 8'hf2;
  localparam logic [7:0]  IDX_PEND   = 8'hf3;
  localparam logic [7:0]  IDX_MASK   = 8'hf4;
  localparam logic [7:0]  IDX_PAIR   = 8'hf5;
  localparam logic [7:0]  IDX_VBASE  = 8'hf6;
  localparam logic [7:0]  IDX_NSTK   = 8'hf7;
  localparam logic [7:0]  IDX_CSEG   = 8'hf8;
  localparam logic [7:0]  IDX_ISEG   = 8'hf9;
  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned CTRL_CPL_LSB  = 0;
  localparam int unsigned CTRL_IEN_BIT  = 4;
  localparam int unsigned CTRL_IAM_BIT  = 5;
  localparam int unsigned CFG_SEGSV_BIT = 0;
  localparam int unsigned CFG_A0SRC_BIT = 1;
  localparam int unsigned CFG_D0SRC_BIT = 2;
  localparam logic [2:0]  CPL_RESET     = 3'h7;
  localparam logic [7:0]  CFG_RESET     = 8'h02;
  localparam logic [2:0]  CHAN_A0       = 3'h0;
  localparam logic [2:0]  CHAN_D0       = 3'h6;
  localparam int unsigned NUM_CHAN      = 8;
  // ==========================================================================
  // Entry and return sequencer
  typedef enum logic [10:0] {
    ST_IDLE      = 11'h001,
    ST_PUSH_PCL  = 11'h002,
    ST_PUSH_PCH  = 11'h004,
    ST_PUSH_CSEG = 11'h008,
    ST_PUSH_FLAG = 11'h010,
    ST_LOAD_PC   = 11'h020,
    ST_POP_FLAG  = 11'h040,
    ST_POP_CSEG  = 11'h080,
    ST_POP_PCH   = 11'h100,
    ST_POP_PCL   = 11'h200,
    ST_RET_END   = 11'h400
  } piu_seq_type;
endpackage : piu_pkg

// >>> inc/piu_edge_if.sv
// Carrier between the register core and the external source front end
`timescale 1ns/100ps
interface piu_edge_if;
  logic [7:0] edge_sel;
  logic       a0_pin_sel;
  logic       d0_pin_sel;
  logic [7:0] set_evt;
  modport core  (output edge_sel, output a0_pin_sel, output d0_pin_sel, input set_evt);
  modport front (input edge_sel, input a0_pin_sel, input d0_pin_sel, output set_evt);
endinterface : piu_edge_if

// >>> rtl/piu_ext_front.sv
// External line synchronisers, source selection and edge detection
`timescale 1ns/100ps
module piu_ext_front (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ext_line_zero,
  input  wire logic ext_line_six,
  input  wire logic timer_wdg_req,
  input  wire logic clk_ctrl_req,
  piu_edge_if.front ev
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] filt;
    logic [1:0] prev;
    logic [7:0] evt;
  } piu_front_type;

  piu_front_type f_q;
  piu_front_type f_d;
  logic [1:0]    src;

  localparam logic [2:0] CHAN_A0 = piu_pkg::CHAN_A0;
  localparam logic [2:0] CHAN_D0 = piu_pkg::CHAN_D0;

  // ==========================================================================
  // Next state
  always_comb begin
    f_d = f_q;
    f_d.s1 = {ext_line_six, ext_line_zero};
    f_d.s2 = f_q.s1;
    f_d.s3 = f_q.s2;
    // A level only counts once two stages agree, filtering metastable flips
    for (int i = 0; i < 2; i++) begin
      if (f_q.s2[i] == f_q.s3[i]) begin
        f_d.filt[i] = f_q.s3[i];
      end
    end
    // On-chip requesters share the same clock, so they bypass the filter
    src[0] = ev.a0_pin_sel ? f_q.filt[0] : timer_wdg_req;
    src[1] = ev.d0_pin_sel ? f_q.filt[1] : clk_ctrl_req;
    f_d.prev = src;
    // Only A0 and D0 have a source; the other channels stay quiet
    f_d.evt = 8'h00;
    f_d.evt[CHAN_A0] = ev.edge_sel[CHAN_A0] ? (src[0] & ~f_q.prev[0])
                                            : (~src[0] & f_q.prev[0]);
    f_d.evt[CHAN_D0] = ev.edge_sel[CHAN_D0] ? (src[1] & ~f_q.prev[1])
                                            : (~src[1] & f_q.prev[1]);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign ev.set_evt = f_q.evt;
endmodule : piu_ext_front

// >>> rtl/piu_top.sv
// Priority interrupt unit: APB registers, arbitration, entry and return sequencer
`timescale 1ns/100ps
module piu_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [piu_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        ext_line_zero,
  input  wire logic                        ext_line_six,
  input  wire logic                        timer_wdg_req,
  input  wire logic                        clk_ctrl_req,
  input  wire logic                        iret_req,
  input  wire logic                        ei_req,
  input  wire logic [15:0]                 cpu_pc,
  input  wire logic [7:0]                  cpu_flags,
  input  wire logic [15:0]                 vec_word,
  input  wire logic [7:0]                  stk_rdata,
  output logic                             int_ack,
  output logic                             stk_push,
  output logic                             stk_pop,
  output logic      [7:0]                  stk_wdata,
  output logic                             pc_load,
  output logic      [15:0]                 pc_value,
  output logic                             flags_load,
  output logic      [7:0]                  flags_value,
  output logic      [7:0]                  vector_pointer,
  output logic      [7:0]                  fetch_segment
);
  typedef struct packed {
    piu_pkg::piu_seq_type st;
    logic [7:0]  edge_sel;
    logic [7:0]  pend;
    logic [7:0]  mask;
    logic [7:0]  pair;
    logic [7:0]  vbase;
    logic [7:0]  nstk;
    logic [2:0]  current_priority_level;
    logic        global_int_enable;
    logic        arbitration_select;
    logic [7:0]  cfg;
    logic [7:0]  cseg;
    logic [7:0]  iseg;
    logic        use_isr;
    logic        ack;
    logic [2:0]  ack_lvl;
    logic        push;
    logic        pop;
    logic [7:0]  wdata;
    logic        pc_ld;
    logic [15:0] pc_val;
    logic        fl_ld;
    logic [7:0]  fl_val;
    logic [7:0]  vptr;
    logic [7:0]  fseg;
    logic        rdy;
    logic        err;
    logic [31:0] rdat;
  } piu_state_type;

  localparam piu_state_type S_RST = '{st: piu_pkg::ST_IDLE, current_priority_level: piu_pkg::CPL_RESET,
                                      cfg: piu_pkg::CFG_RESET, default: '0};

  piu_state_type s_q;
  piu_state_type s_d;
  piu_edge_if    ev ();

  // ==========================================================================
  // Helpers
  // Even channel of a pair takes the even level, odd channel the next one
  function automatic logic [2:0] chan_level(input logic [7:0] pair, input logic [2:0] ch);
    chan_level = {pair[{ch[2:1], 1'b0} +: 2], ch[0]};
  endfunction : chan_level

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    lowest_set = 3'h0;
    for (int i = piu_pkg::NUM_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = 3'(i);
      end
    end
  endfunction : lowest_set

  // ==========================================================================
  // External source front end
  piu_ext_front u_front (
    .pclk          (pclk),
    .presetn       (presetn),
    .ext_line_zero (ext_line_zero),
    .ext_line_six  (ext_line_six),
    .timer_wdg_req (timer_wdg_req),
    .clk_ctrl_req  (clk_ctrl_req),
    .ev            (ev.front)
  );

  assign ev.edge_sel   = s_q.edge_sel;
  assign ev.a0_pin_sel = s_q.cfg[piu_pkg::CFG_A0SRC_BIT];
  assign ev.d0_pin_sel = ~s_q.cfg[piu_pkg::CFG_D0SRC_BIT];

  // ==========================================================================
  // Combinational next state
  logic [7:0] idx;
  logic       acc;
  logic       wr;
  logic       segsv;
  logic [7:0] req;
  logic [7:0] clr;
  logic       found;
  logic [2:0] best_lvl;
  logic [2:0] best_ch;
  logic [2:0] lvl;

  always_comb begin
    s_d      = s_q;
    idx      = paddr[piu_pkg::APB_AW-1:2];
    acc      = psel & penable;
    wr       = acc & s_q.rdy & pwrite;
    segsv    = s_q.cfg[piu_pkg::CFG_SEGSV_BIT];
    clr      = 8'h00;
    found    = 1'b0;
    best_lvl = 3'h7;
    best_ch  = 3'h0;
    lvl      = 3'h0;
    s_d.ack   = 1'b0;
    s_d.push  = 1'b0;
    s_d.pop   = 1'b0;
    s_d.pc_ld = 1'b0;
    s_d.fl_ld = 1'b0;
    // One wait state: answer lands on the second access cycle
    s_d.rdy  = acc & ~s_q.rdy;
    s_d.err  = 1'b0;
    s_d.rdat = 32'h0000_0000;
    if (acc && !s_q.rdy) begin
      unique case (idx)
        piu_pkg::IDX_CTRL:  s_d.rdat[7:0] = {2'b00, s_q.arbitration_select, s_q.global_int_enable, 1'b0, s_q.current_priority_level};
        piu_pkg::IDX_CFG:   s_d.rdat[7:0] = s_q.cfg;
        piu_pkg::IDX_EDGE:  s_d.rdat[7:0] = s_q.edge_sel;
        piu_pkg::IDX_PEND:  s_d.rdat[7:0] = s_q.pend;
        piu_pkg::IDX_MASK:  s_d.rdat[7:0] = s_q.mask;
        piu_pkg::IDX_PAIR:  s_d.rdat[7:0] = s_q.pair;
        piu_pkg::IDX_VBASE: s_d.rdat[7:0] = s_q.vbase;
        piu_pkg::IDX_NSTK:  s_d.rdat[7:0] = s_q.nstk;
        piu_pkg::IDX_CSEG:  s_d.rdat[7:0] = s_q.cseg;
        piu_pkg::IDX_ISEG:  s_d.rdat[7:0] = s_q.iseg;
        default:            s_d.err = 1'b1;
      endcase
    end
    // Software writes first; the sequencer below overrides on a collision
    if (wr) begin
      unique case (idx)
        piu_pkg::IDX_CTRL: begin
          s_d.current_priority_level = pwdata[piu_pkg::CTRL_CPL_LSB +: 3];
          s_d.global_int_enable = pwdata[piu_pkg::CTRL_IEN_BIT];
          s_d.arbitration_select = pwdata[piu_pkg::CTRL_IAM_BIT];
        end
        piu_pkg::IDX_CFG:   s_d.cfg      = pwdata[7:0];
        piu_pkg::IDX_EDGE:  s_d.edge_sel = pwdata[7:0];
        piu_pkg::IDX_PEND:  s_d.pend     = pwdata[7:0];
        piu_pkg::IDX_MASK:  s_d.mask     = pwdata[7:0];
        piu_pkg::IDX_PAIR:  s_d.pair     = pwdata[7:0];
        piu_pkg::IDX_VBASE: s_d.vbase    = pwdata[7:0];
        piu_pkg::IDX_NSTK:  s_d.nstk     = pwdata[7:0];
        piu_pkg::IDX_CSEG:  s_d.cseg     = pwdata[7:0];
        piu_pkg::IDX_ISEG:  s_d.iseg     = pwdata[7:0];
        default:            s_d.err = 1'b0;
      endcase
    end
    // Arbitration; mask is stored A0 at the top bit, ties go to lower channel
    for (int i = 0; i < piu_pkg::NUM_CHAN; i++) begin
      req[i] = s_q.pend[i] & s_q.mask[piu_pkg::NUM_CHAN - 1 - i];
      lvl    = chan_level(s_q.pair, 3'(i));
      if (req[i] && (!found || lvl < best_lvl)) begin
        found    = 1'b1;
        best_lvl = lvl;
        best_ch  = 3'(i);
      end
    end
    // Sequencer
    unique case (s_q.st)
      piu_pkg::ST_IDLE: begin
        if (iret_req) begin
          s_d.pop = 1'b1;
          s_d.st  = piu_pkg::ST_POP_FLAG;
        end else if (s_q.global_int_enable && found && best_lvl < s_q.current_priority_level) begin
          s_d.ack     = 1'b1;
          s_d.ack_lvl = best_lvl;
          s_d.global_int_enable     = 1'b0;
          clr[best_ch] = 1'b1;
          s_d.vptr    = {s_q.vbase[7:4], best_ch, 1'b0};
          // Concurrent mode leaves the level untouched
          if (s_q.arbitration_select) begin
            s_d.nstk[s_q.current_priority_level] = 1'b1;
            s_d.current_priority_level           = best_lvl;
          end
          s_d.push  = 1'b1;
          s_d.wdata = cpu_pc[7:0];
          s_d.st    = piu_pkg::ST_PUSH_PCL;
        end else if (ei_req) begin
          s_d.global_int_enable = 1'b1;
        end
      end
      piu_pkg::ST_PUSH_PCL: begin
        s_d.push  = 1'b1;
        s_d.wdata = cpu_pc[15:8];
        s_d.st    = piu_pkg::ST_PUSH_PCH;
      end
      piu_pkg::ST_PUSH_PCH: begin
        s_d.push  = 1'b1;
        s_d.wdata = segsv ? s_q.cseg : cpu_flags;
        s_d.st    = segsv ? piu_pkg::ST_PUSH_CSEG : piu_pkg::ST_PUSH_FLAG;
      end
      piu_pkg::ST_PUSH_CSEG: begin
        s_d.push  = 1'b1;
        s_d.wdata = cpu_flags;
        s_d.st    = piu_pkg::ST_PUSH_FLAG;
      end
      piu_pkg::ST_PUSH_FLAG: begin
        s_d.st = piu_pkg::ST_LOAD_PC;
      end
      piu_pkg::ST_LOAD_PC: begin
        s_d.pc_ld  = 1'b1;
        s_d.pc_val = vec_word;
        if (segsv) begin
          s_d.cseg = s_q.iseg;
        end else begin
          s_d.use_isr = 1'b1;
        end
        s_d.st = piu_pkg::ST_IDLE;
      end
      piu_pkg::ST_POP_FLAG: begin
        s_d.fl_ld  = 1'b1;
        s_d.fl_val = stk_rdata;
        s_d.pop    = 1'b1;
        s_d.st     = segsv ? piu_pkg::ST_POP_CSEG : piu_pkg::ST_POP_PCH;
      end
      piu_pkg::ST_POP_CSEG: begin
        s_d.cseg = stk_rdata;
        s_d.pop  = 1'b1;
        s_d.st   = piu_pkg::ST_POP_PCH;
      end
      piu_pkg::ST_POP_PCH: begin
        s_d.pc_val[15:8] = stk_rdata;
        s_d.pop          = 1'b1;
        s_d.st           = piu_pkg::ST_POP_PCL;
      end
      piu_pkg::ST_POP_PCL: begin
        s_d.pc_val[7:0] = stk_rdata;
        s_d.pc_ld       = 1'b1;
        s_d.st          = piu_pkg::ST_RET_END;
      end
      piu_pkg::ST_RET_END: begin
        s_d.global_int_enable = 1'b1;
        // An empty stack means nothing nested to restore
        if (s_q.arbitration_select && s_q.nstk != 8'h00) begin
          s_d.current_priority_level = lowest_set(s_q.nstk);
          s_d.nstk[lowest_set(s_q.nstk)] = 1'b0;
        end
        if (!segsv) begin
          if (!s_q.arbitration_select) begin
            s_d.use_isr = 1'b0;
          end else if ((s_q.nstk & ~(8'h01 << lowest_set(s_q.nstk))) == 8'h00) begin
            s_d.use_isr = 1'b0;
          end
        end
        s_d.st = piu_pkg::ST_IDLE;
      end
      default: s_d.st = piu_pkg::ST_IDLE;
    endcase
    // Hardware set wins over clearing by acknowledge or by software
    s_d.pend = (s_d.pend & ~clr) | ev.set_evt;
    s_d.fseg = s_d.use_isr ? s_d.iseg : s_d.cseg;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign prdata         = s_q.rdat;
  assign pready         = s_q.rdy;
  assign pslverr        = s_q.err;
  assign int_ack        = s_q.ack;
  assign stk_push       = s_q.push;
  assign stk_pop        = s_q.pop;
  assign stk_wdata      = s_q.wdata;
  assign pc_load        = s_q.pc_ld;
  assign pc_value       = s_q.pc_val;
  assign flags_load     = s_q.fl_ld;
  assign flags_value    = s_q.fl_val;
  assign vector_pointer = s_q.vptr;
  assign fetch_segment  = s_q.fseg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IRET_ORDER: assert property (
    s_q.st == piu_pkg::ST_POP_PCH |=> s_q.st == piu_pkg::ST_POP_PCL && s_q.pop
      ##1 s_q.st == piu_pkg::ST_RET_END ##1 s_q.global_int_enable)
    else $error("return sequence out of order");
  AST_CONC_SEG_BACK: assert property (
    s_q.st == piu_pkg::ST_RET_END && !s_q.arbitration_select && !s_q.cfg[piu_pkg::CFG_SEGSV_BIT]
      |=> !s_q.use_isr && fetch_segment == s_q.cseg)
    else $error("concurrent return kept interrupt segment");
  AST_NO_ACK_DISABLED: assert property (
    !s_q.global_int_enable |=> !int_ack)
    else $error("acknowledge while disabled");
  AST_CONC_CPL_KEPT: assert property (
    int_ack && !s_q.arbitration_select |-> s_q.current_priority_level == $past(s_q.current_priority_level))
    else $error("concurrent acknowledge changed level");
  AST_NEST_SAVE: assert property (
    int_ack && s_q.arbitration_select |-> s_q.nstk[$past(s_q.current_priority_level)] && s_q.current_priority_level == s_q.ack_lvl)
    else $error("nested save or load wrong");
  AST_ENTRY_ORDER: assert property (
    int_ack |-> !s_q.global_int_enable && stk_push && stk_wdata == $past(cpu_pc[7:0])
      ##1 stk_push ##1 stk_push ##[1:2] s_q.st == piu_pkg::ST_LOAD_PC ##1 pc_load)
    else $error("entry sequence out of order");
  AST_SEG_LOAD: assert property (
    s_q.st == piu_pkg::ST_LOAD_PC && s_q.cfg[piu_pkg::CFG_SEGSV_BIT]
      |=> s_q.cseg == $past(s_q.iseg))
    else $error("code segment not loaded at entry");
  AST_STRICT_LEVEL: assert property (
    int_ack |-> s_q.ack_lvl < $past(s_q.current_priority_level))
    else $error("acknowledged level not below current");
  AST_NEST_POP: assert property (
    s_q.st == piu_pkg::ST_RET_END && s_q.arbitration_select && s_q.nstk != 8'h00
      |=> s_q.current_priority_level == lowest_set($past(s_q.nstk)) && !s_q.nstk[s_q.current_priority_level])
    else $error("nested return restored wrong level");
  AST_PEND_SET: assert property (
    ev.set_evt[piu_pkg::CHAN_A0] |=> s_q.pend[piu_pkg::CHAN_A0])
    else $error("edge event lost");

  COV_NEST_ACK: cover property (int_ack && s_q.arbitration_select);
  COV_RET_DONE: cover property (s_q.st == piu_pkg::ST_RET_END ##1 s_q.global_int_enable);
  COV_LINE_SIX: cover property (ev.set_evt[piu_pkg::CHAN_D0]);
endmodule : piu_top

// >>> bench/piu_cpu_model.sv
// CPU-side stack and vector table model for the priority interrupt unit
`timescale 1ns/100ps
module piu_cpu_model (
  input  wire logic        pclk,
  input  wire logic        stk_push,
  input  wire logic        stk_pop,
  input  wire logic [7:0]  stk_wdata,
  input  wire logic [7:0]  vector_pointer,
  output logic      [7:0]  stk_rdata,
  output logic      [15:0] vec_word
);
  // ==========================================================================
  // Byte stack
  logic [7:0] mem [0:15];
  logic [3:0] sp = 4'h0;
  // Top byte shown only while popping, inverted otherwise so stale reads show up
  assign stk_rdata = stk_pop ? mem[sp - 4'h1] : ~mem[sp - 4'h1];
  // Vector table word holds a fixed high byte and the pointer itself
  assign vec_word = {8'hc3, vector_pointer};
  // One byte moves per strobed cycle
  always @(posedge pclk) begin
    if (stk_push) begin
      mem[sp] <= stk_wdata;
      sp <= sp + 4'h1;
    end else if (stk_pop) begin
      sp <= sp - 4'h1;
    end
  end
endmodule : piu_cpu_model

// >>> bench/priority_interrupt_unit_tb_top.sv
// Self-checking bench of the priority interrupt unit
`timescale 1ns/100ps
module priority_interrupt_unit_tb_top;
  // ==========================================================================
  // Signals and scoreboard
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, lfsr = 32'h2c4e;
  logic        pready, pslverr, ext0 = 0, ext6 = 1, iret = 0;
  logic        tmr = 0, clkc = 1, ei = 0, err_exp = 0, sv = 0;
  logic        int_ack, stk_push, stk_pop, pc_load, flags_load;
  logic [15:0] cpu_pc = '0, vec_word, pc_value, ret_pc;
  logic [7:0]  cpu_flags = '0, stk_rdata, stk_wdata, flags_value, ret_fl;
  logic [7:0]  vector_pointer, fetch_segment;
  logic [7:0]  exp_rd[$], exp_stk[$];
  logic [15:0] exp_pc[$];
  int          bad_count = 0, total_checks = 0, ack_cnt = 0;
  always #25 pclk = ~pclk;
  piu_top u_piu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_line_zero(ext0), .ext_line_six(ext6), .timer_wdg_req(tmr),
    .clk_ctrl_req(clkc), .iret_req(iret), .ei_req(ei), .cpu_pc(cpu_pc),
    .cpu_flags(cpu_flags), .vec_word(vec_word), .stk_rdata(stk_rdata), .int_ack(int_ack),
    .stk_push(stk_push), .stk_pop(stk_pop), .stk_wdata(stk_wdata), .pc_load(pc_load),
    .pc_value(pc_value), .flags_load(flags_load), .flags_value(flags_value),
    .vector_pointer(vector_pointer), .fetch_segment(fetch_segment));
  piu_cpu_model u_piu_cpu_model (.pclk(pclk), .stk_push(stk_push), .stk_pop(stk_pop),
    .stk_wdata(stk_wdata), .vector_pointer(vector_pointer), .stk_rdata(stk_rdata),
    .vec_word(vec_word));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test;
    end else begin
      psel <= 0;
      penable <= 0;
      // Idle cycle so that a following call never rewrites psel in one time step
      @(posedge pclk);
    end
  endtask : apb
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_rd.push_back(e);
    apb(0, idx, 8'h00);
  endtask : rd
  // Bounded wait for the program counter load that ends a sequence
  task automatic wait_pc;
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      finish_test;
    end else begin
      repeat (3) @(posedge pclk);
    end
  endtask : wait_pc
  task automatic enter(input logic [7:0] ctrl);
    lfsr = nxt(lfsr);
    cpu_pc <= lfsr[15:0];
    cpu_flags <= lfsr[23:16];
    ret_pc = lfsr[15:0];
    ret_fl = lfsr[23:16];
    exp_stk.push_back(lfsr[7:0]);
    exp_stk.push_back(lfsr[15:8]);
    if (sv) exp_stk.push_back(8'h5e);
    exp_stk.push_back(lfsr[23:16]);
    exp_pc.push_back(16'hc350);
    apb(1, piu_pkg::IDX_CTRL, ctrl);
    // Enable left clear: only the enable instruction may release the request
    if (!ctrl[piu_pkg::CTRL_IEN_BIT]) begin
      ei <= 1;
      @(posedge pclk);
      ei <= 0;
    end
    wait_pc;
    chk("fetch_segment", 16'h9a, fetch_segment);
  endtask : enter
  task automatic leave;
    exp_pc.push_back(ret_pc);
    iret <= 1;
    @(posedge pclk);
    iret <= 0;
    wait_pc;
    chk("fetch_segment", 16'h5e, fetch_segment);
  endtask : leave
  // Watcher takes the oldest note whenever a result appears
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_rd.size() > 0)
      chk("prdata", {8'h0, exp_rd.pop_front()}, prdata[15:0]);
    if (psel && penable && pready === 1'b1) chk("pslverr", {15'h0, err_exp}, {15'h0, pslverr});
    if (stk_push === 1'b1) chk("stk_wdata", exp_stk.pop_front(), stk_wdata);
    if (pc_load === 1'b1) chk("pc_value", exp_pc.pop_front(), pc_value);
    if (flags_load === 1'b1) chk("flags_value", ret_fl, flags_value);
    if (int_ack === 1'b1) ack_cnt++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    finish_test;
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rd(piu_pkg::IDX_CTRL, 8'h07);
    rd(piu_pkg::IDX_CFG, 8'h02);
    err_exp <= 1'b1;
    rd(8'h10, 8'h00);
    err_exp <= 1'b0;
    $display("test reset done");
    apb(1, piu_pkg::IDX_EDGE, 8'h01);
    ext0 <= 1;
    ext6 <= 0;
    repeat (8) @(posedge pclk);
    rd(piu_pkg::IDX_PEND, 8'h41);
    $display("test edges done");
    apb(1, piu_pkg::IDX_MASK, 8'h80);
    apb(1, piu_pkg::IDX_PAIR, 8'h01);
    apb(1, piu_pkg::IDX_VBASE, 8'h50);
    apb(1, piu_pkg::IDX_ISEG, 8'h9a);
    apb(1, piu_pkg::IDX_CSEG, 8'h5e);
    enter(8'h37);
    rd(piu_pkg::IDX_CTRL, 8'h22);
    rd(piu_pkg::IDX_NSTK, 8'h80);
    leave;
    rd(piu_pkg::IDX_CTRL, 8'h37);
    rd(piu_pkg::IDX_NSTK, 8'h00);
    $display("test nested done");
    apb(1, piu_pkg::IDX_CTRL, 8'h32);
    apb(1, piu_pkg::IDX_PEND, 8'h01);
    repeat (10) @(posedge pclk);
    chk("ack_count", 16'h1, ack_cnt[15:0]);
    enter(8'h13);
    rd(piu_pkg::IDX_CTRL, 8'h03);
    leave;
    rd(piu_pkg::IDX_CTRL, 8'h13);
    $display("test concurrent done");
    // On-chip sources selected, segment saving on, enable cleared
    apb(1, piu_pkg::IDX_CTRL, 8'h03);
    apb(1, piu_pkg::IDX_CFG, 8'h05);
    apb(1, piu_pkg::IDX_PEND, 8'h00);
    ext0 <= 0;
    ext6 <= 1;
    repeat (8) @(posedge pclk);
    ext0 <= 1;
    ext6 <= 0;
    repeat (8) @(posedge pclk);
    rd(piu_pkg::IDX_PEND, 8'h00);
    tmr <= 1;
    clkc <= 0;
    repeat (4) @(posedge pclk);
    rd(piu_pkg::IDX_PEND, 8'h41);
    chk("ack_count", 16'h2, ack_cnt[15:0]);
    $display("test sources done");
    sv = 1;
    enter(8'h03);
    leave;
    $display("test enable done");
    finish_test;
  end
endmodule : priority_interrupt_unit_tb_top
